// File: hdl/ext_port_pkg.sv
package ext_port_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFF_BANK_CTL0   = 8'h00;
    localparam logic [7:0] OFF_BOOT_CTL    = 8'h10;
    localparam logic [7:0] OFF_IO_CTL      = 8'h14;
    localparam logic [7:0] OFF_PAGE_10     = 8'h18;
    localparam logic [7:0] OFF_PAGE_32     = 8'h1c;
    localparam logic [7:0] OFF_PORT_CTL    = 8'h20;
    localparam logic [7:0] OFF_EXT_STATE   = 8'h24;
    localparam logic [7:0] OFF_WR_STATUS   = 8'h28;

    // Space control field positions
    localparam int RWC_LSB = 0;
    localparam int WWC_LSB = 3;
    localparam int WMS_LSB = 6;
    localparam int CDS_LSB = 8;
    localparam int WHE_BIT = 11;

    // Status and port control field positions
    localparam int BSY_LSB     = 0;
    localparam int OWNER_LSB   = 2;
    localparam int PACK_LSB    = 7;
    localparam int WPEND_BIT   = 8;
    localparam int LOCK_BIT    = 0;

    // Reset values
    localparam logic [15:0] SPACE_CTL_RST = 16'h0000;
    localparam logic [7:0]  BANK1_PG_RST  = 8'h40;
    localparam logic [7:0]  BANK2_PG_RST  = 8'h80;
    localparam logic [7:0]  BANK3_PG_RST  = 8'hc0;
    localparam logic [7:0]  BANK0_PG_RST  = 8'h01;

    // Ack mode takes at least this many waitstates
    localparam logic [2:0] ACK_MIN_WAIT = 3'h2;

    localparam logic [1:0] BSY_IDLE    = 2'h0;
    localparam logic [1:0] BSY_OFFCHIP = 2'h1;
    localparam logic [1:0] BSY_ONCHIP  = 2'h2;

    typedef enum logic [1:0] {
        WMS_ACK    = 2'b00,
        WMS_COUNT  = 2'b01,
        WMS_BOTH   = 2'b10,
        WMS_EITHER = 2'b11
    } wait_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_STROBE = 3'b001,
        ST_HOLD   = 3'b010,
        ST_GRANT  = 3'b011
    } port_state_t;

    typedef struct packed {
        logic [3:0] unused;
        logic       write_hold_en;
        logic [2:0] clk_div_select;
        wait_mode_t wait_mode_select;
        logic [2:0] write_wait_count;
        logic [2:0] read_wait_count;
    } space_ctl_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        boot;
        logic        io;
        logic [21:0] addr;
        logic [15:0] wdata;
        logic [4:0]  owner;
    } mem_req_t;

endpackage

// File: hdl/ext_mem_port.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - Mode 00: access ends only on acknowledge, at least two waitstates.
// - Mode 01: acknowledge ignored, reads/writes use their own counts.
// - Mode 10: count expired and acknowledge both needed to end.
// - Mode 11: count expiry or acknowledge, whichever first, ends access.
// - Separate 3-bit read/write waitstate counts, 0 to 7 cycles.
// - Write hold keeps address and data one cycle past strobe release.
// - Hold cycle applied in every waitstate mode.
// - Per-space clock divider select: 1,2,4,8,16,32.
// - After reset four banks of about 64 pages each.
// - Bank 0 starts at page 0x01 (address 0x4000); matching bank select asserted.
// - Write pending flag bit 8 set while write outstanding.
// - Bus busy bits 1-0: idle, off-chip, on-chip owner.
// - Bits 6-2 hold current or last owner identifier.
// - Bits 8-7 report packer byte fill.
// - Core not stalled by writes; software polls write pending.
// - Idle port grants a request once it has passed the two-flop synchroniser, drivers off.
// - Core stalls only when it needs external access during grant.
// - Request during access is granted after the access finishes.
// - Request removal drops grant, re-enables drivers, resumes.
// - Requests honoured during boot; grant held off while presetn is low.
// - Grant-hung asserted when access waits on granted bus.
// - Wait mode select at bits 7-6 of each control register.
// - Divider select at bits 10-8 of each control register.
// - Bus lock set ignores external requests.
module ext_mem_port
    import ext_port_pkg::*;
(
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core request side
    input  wire mem_req_t    core_req,
    input  wire logic        core_booting,
    input  wire logic [1:0]  packer_fill,
    output logic             core_stall,
    output logic             core_done,
    output logic      [15:0] core_rdata,
    // External memory pins
    input  wire logic        ack,
    input  wire logic [15:0] data_in,
    output logic      [21:0] addr_out,
    output logic      [15:0] data_out,
    output logic             data_oe_n,
    output logic             addr_oe_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic      [3:0]  bank_select_lines,
    output logic             boot_space_select_n,
    output logic             io_space_select_n,
    output logic             mem_iface_clk,
    // Bus arbitration
    input  wire logic        bus_request_n,
    output logic             bus_grant_n,
    output logic             grant_hung_n
);

    // Control and state registers
    space_ctl_t  bank_ctl_q [4];
    space_ctl_t  bootspace_ctl_q;
    space_ctl_t  iospace_ctl_q;
    logic [7:0]  bank_low_page_q [4];
    logic        bus_lock_q;
    logic        write_pending_q;
    logic [1:0]  ext_bus_busy_q;
    logic [4:0]  owner_q;
    logic [1:0]  fill_q;
    port_state_t state_q;
    mem_req_t    req_q;
    space_ctl_t  cur_ctl_q;
    logic [2:0]  wait_q;
    logic [4:0]  div_q;
    logic        tick_q;
    logic        ack_meta_q, ack_q;
    logic        breq_meta_q, breq_q;
    logic        boot_lat_q;

    // Synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_meta_q  <= 1'b0;
            ack_q       <= 1'b0;
            breq_meta_q <= 1'b1;
            breq_q      <= 1'b1;
        end else begin
            ack_meta_q  <= ack;
            ack_q       <= ack_meta_q;
            breq_meta_q <= bus_request_n;
            breq_q      <= breq_meta_q;
        end
    end

    // Bank decode on page number (address bits 21:14)
    wire [7:0] req_page = core_req.addr[21:14];
    logic [3:0] bank_hit;
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_bank
            if (gb < 3) begin : g_mid
                assign bank_hit[gb] = (req_page >= bank_low_page_q[gb]) &&
                                      (req_page <  bank_low_page_q[gb+1]);
            end else begin : g_top
                assign bank_hit[gb] = (req_page >= bank_low_page_q[gb]);
            end
        end
    endgenerate

    wire [1:0] bank_idx = bank_hit[3] ? 2'd3 : bank_hit[2] ? 2'd2 :
                          bank_hit[1] ? 2'd1 : 2'd0;
    wire       bank_any = |bank_hit;
    wire space_ctl_t sel_ctl = core_req.boot ? bootspace_ctl_q :
                               core_req.io   ? iospace_ctl_q   : bank_ctl_q[bank_idx];

    wire req_active  = !breq_q && !bus_lock_q;
    wire start_ok    = core_req.valid && (core_req.boot || core_req.io || bank_any);
    wire in_reset_gr = core_booting && !boot_lat_q;

    wire [2:0] cnt_sel = req_q.write ? cur_ctl_q.write_wait_count :
                                       cur_ctl_q.read_wait_count;
    wire       cnt_done = (wait_q >= cnt_sel);
    wire       ack_min  = (wait_q >= ACK_MIN_WAIT);
    logic      finish;
    always_comb begin
        unique case (cur_ctl_q.wait_mode_select)
            WMS_ACK:    finish = ack_q && ack_min;
            WMS_COUNT:  finish = cnt_done;
            WMS_BOTH:   finish = cnt_done && ack_q;
            WMS_EITHER: finish = cnt_done || ack_q;
        endcase
    end

    wire [4:0] div_max = 5'((6'h01 << cur_ctl_q.clk_div_select) - 6'h01);
    wire       div_end = (div_q >= div_max) || (cur_ctl_q.clk_div_select > 3'h5);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q         <= 5'h00;
            tick_q        <= 1'b0;
            mem_iface_clk <= 1'b0;
        end else begin
            // Restart in idle so every access starts on a whole period
            div_q         <= (div_end || state_q == ST_IDLE) ? 5'h00 : 5'(div_q + 5'h01);
            tick_q        <= div_end;
            mem_iface_clk <= (div_q > (div_max >> 1)) || div_end;
        end
    end

    // Pins lag state by one edge; count only once the strobe is out
    wire strobe_on = !rd_n || !wr_n;

    // Port sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= ST_IDLE;
            req_q     <= '0;
            cur_ctl_q <= SPACE_CTL_RST;
            wait_q    <= 3'h0;
            core_done <= 1'b0;
            core_rdata <= 16'h0000;
        end else begin
            core_done <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (req_active) begin
                        state_q <= ST_GRANT;
                    end else if (start_ok) begin
                        state_q   <= ST_STROBE;
                        req_q     <= core_req;
                        cur_ctl_q <= sel_ctl;
                        wait_q    <= 3'h0;
                    end
                end
                ST_STROBE: begin
                    if (tick_q && strobe_on) begin
                        if (finish) begin
                            core_done  <= 1'b1;
                            core_rdata <= data_in;
                            state_q <= (req_q.write && cur_ctl_q.write_hold_en) ?
                                       ST_HOLD : ST_IDLE;
                        end else if (wait_q != 3'h7) begin
                            wait_q <= 3'(wait_q + 3'h1);
                        end
                    end
                end
                ST_HOLD: begin
                    if (tick_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_GRANT: begin
                    if (!req_active) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    wire granted = (state_q == ST_GRANT) && req_active;
    wire busy    = (state_q == ST_STROBE) || (state_q == ST_HOLD);

    // Pin drivers and arbitration outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_out            <= 22'h000000;
            data_out            <= 16'h0000;
            data_oe_n           <= 1'b1;
            addr_oe_n           <= 1'b0;
            rd_n                <= 1'b1;
            wr_n                <= 1'b1;
            bank_select_lines   <= 4'hf;
            boot_space_select_n <= 1'b1;
            io_space_select_n   <= 1'b1;
            bus_grant_n         <= 1'b1;
            grant_hung_n        <= 1'b1;
            core_stall          <= 1'b0;
            boot_lat_q          <= 1'b0;
        end else begin
            boot_lat_q <= core_booting;
            bus_grant_n <= !(granted || (in_reset_gr && req_active && !busy));
            addr_oe_n   <= granted;
            data_oe_n   <= granted || !(busy && req_q.write);
            addr_out    <= req_q.addr;
            data_out    <= req_q.wdata;
            rd_n        <= !((state_q == ST_STROBE) && !req_q.write);
            wr_n        <= !((state_q == ST_STROBE) && req_q.write);
            bank_select_lines <= (busy && !req_q.boot && !req_q.io) ?
                                 ~(4'h1 << bank_idx_q()) : 4'hf;
            boot_space_select_n <= !(busy && req_q.boot);
            io_space_select_n   <= !(busy && req_q.io);
            grant_hung_n <= !(granted && core_req.valid);
            core_stall   <= granted && core_req.valid;
        end
    end

    // Bank of the latched request
    function automatic logic [1:0] bank_idx_q();
        logic [7:0] pg;
        pg = req_q.addr[21:14];
        if (pg >= bank_low_page_q[3]) return 2'd3;
        if (pg >= bank_low_page_q[2]) return 2'd2;
        if (pg >= bank_low_page_q[1]) return 2'd1;
        return 2'd0;
    endfunction

    // APB slave, zero wait states
    wire       apb_wr   = psel && penable && pwrite;
    wire       apb_rd   = psel && !penable && !pwrite;
    wire       hit_bank = (paddr < OFF_BOOT_CTL) && (paddr[1:0] == 2'b00);
    wire [1:0] ctl_idx  = paddr[3:2];
    wire       mapped   = hit_bank || (paddr == OFF_BOOT_CTL) || (paddr == OFF_IO_CTL) ||
                          (paddr == OFF_PAGE_10) || (paddr == OFF_PAGE_32) ||
                          (paddr == OFF_PORT_CTL) || (paddr == OFF_EXT_STATE) ||
                          (paddr == OFF_WR_STATUS);
    wire [15:0] state_word = {7'h00, fill_q, owner_q, ext_bus_busy_q};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_bank)                    rd_mux = {16'h0000, bank_ctl_q[ctl_idx]};
        else if (paddr == OFF_BOOT_CTL)  rd_mux = {16'h0000, bootspace_ctl_q};
        else if (paddr == OFF_IO_CTL)    rd_mux = {16'h0000, iospace_ctl_q};
        else if (paddr == OFF_PAGE_10)   rd_mux = {16'h0000, bank_low_page_q[1], bank_low_page_q[0]};
        else if (paddr == OFF_PAGE_32)   rd_mux = {16'h0000, bank_low_page_q[3], bank_low_page_q[2]};
        else if (paddr == OFF_PORT_CTL)  rd_mux = {31'h0, bus_lock_q};
        else if (paddr == OFF_EXT_STATE) rd_mux = {16'h0000, state_word};
        else if (paddr == OFF_WR_STATUS) rd_mux = {23'h0, write_pending_q, 8'h00};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                bank_ctl_q[i] <= SPACE_CTL_RST;
            end
            bootspace_ctl_q    <= SPACE_CTL_RST;
            iospace_ctl_q      <= SPACE_CTL_RST;
            bank_low_page_q[0] <= BANK0_PG_RST;
            bank_low_page_q[1] <= BANK1_PG_RST;
            bank_low_page_q[2] <= BANK2_PG_RST;
            bank_low_page_q[3] <= BANK3_PG_RST;
            bus_lock_q         <= 1'b0;
            prdata             <= 32'h0000_0000;
            pready             <= 1'b0;
            pslverr            <= 1'b0;
        end else begin
            pready  <= apb_rd || (psel && !penable && pwrite);
            pslverr <= psel && !penable && !mapped;
            if (apb_rd) begin
                prdata <= rd_mux;
            end
            if (apb_wr) begin
                if (hit_bank)                   bank_ctl_q[ctl_idx] <= pwdata[15:0];
                if (paddr == OFF_BOOT_CTL)      bootspace_ctl_q     <= pwdata[15:0];
                if (paddr == OFF_IO_CTL)        iospace_ctl_q       <= pwdata[15:0];
                if (paddr == OFF_PAGE_10) begin
                    bank_low_page_q[0] <= pwdata[7:0];
                    bank_low_page_q[1] <= pwdata[15:8];
                end
                if (paddr == OFF_PAGE_32) begin
                    bank_low_page_q[2] <= pwdata[7:0];
                    bank_low_page_q[3] <= pwdata[15:8];
                end
                if (paddr == OFF_PORT_CTL)      bus_lock_q <= pwdata[LOCK_BIT];
            end
        end
    end

    // Status tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_pending_q <= 1'b0;
            ext_bus_busy_q  <= BSY_IDLE;
            owner_q         <= 5'h00;
            fill_q          <= 2'h0;
        end else begin
            fill_q <= packer_fill;
            if (state_q == ST_IDLE && start_ok && !req_active && core_req.write) begin
                write_pending_q <= 1'b1;
            end else if (core_done || (state_q == ST_IDLE)) begin
                write_pending_q <= 1'b0;
            end
            if (granted) begin
                ext_bus_busy_q <= BSY_OFFCHIP;
            end else if (busy) begin
                ext_bus_busy_q <= BSY_ONCHIP;
                owner_q        <= req_q.owner;
            end else begin
                ext_bus_busy_q <= BSY_IDLE;
            end
        end
    end

endmodule // ext_mem_port

// File: dv/ext_mem_port_checker.sv
`timescale 1ns/100ps
module ext_mem_port_checker
    import ext_port_pkg::*;
(
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Register bus
    input wire logic       pready,
    input wire logic       pslverr,
    // Core side
    input wire logic       core_stall,
    // Memory pins
    input wire logic       addr_oe_n,
    input wire logic       data_oe_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [3:0] bank_select_lines,
    input wire logic       boot_space_select_n,
    input wire logic       io_space_select_n,
    // Arbitration
    input wire logic       bus_request_n,
    input wire logic       bus_grant_n,
    input wire logic       grant_hung_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Request gone long enough to pass the synchroniser
    sequence s_req_gone;
        bus_request_n [*4];
    endsequence

    property p_float;
        !bus_grant_n |-> addr_oe_n && data_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("buses driven while granted");

    property p_release;
        s_req_gone |=> bus_grant_n;
    endproperty
    a_release: assert property (p_release) else $error("grant kept after release");

    property p_hung;
        !grant_hung_n |-> !bus_grant_n || !$past(bus_grant_n);
    endproperty
    a_hung: assert property (p_hung) else $error("hung flag without grant");

    property p_stall;
        core_stall |-> !bus_grant_n || !$past(bus_grant_n);
    endproperty
    a_stall: assert property (p_stall) else $error("core stalled without grant");

    property p_sel;
        $onehot0({~bank_select_lines, ~boot_space_select_n, ~io_space_select_n});
    endproperty
    a_sel: assert property (p_sel) else $error("several selects active");

    property p_strobe;
        rd_n || wr_n;
    endproperty
    a_strobe: assert property (p_strobe) else $error("read and write strobes together");

    property p_wdrive;
        !wr_n |-> !data_oe_n && !addr_oe_n;
    endproperty
    a_wdrive: assert property (p_wdrive) else $error("write strobe with buses off");

    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");

    property p_gidle;
        $fell(bus_grant_n) |-> rd_n && wr_n;
    endproperty
    a_gidle: assert property (p_gidle) else $error("grant during access");
endmodule // ext_mem_port_checker

bind ext_mem_port ext_mem_port_checker u_chk (
    .pclk, .presetn, .pready, .pslverr, .core_stall, .addr_oe_n, .data_oe_n,
    .rd_n, .wr_n, .bank_select_lines, .boot_space_select_n, .io_space_select_n,
    .bus_request_n, .bus_grant_n, .grant_hung_n
);

// File: dv/ext_mem_model.sv
`timescale 1ns/100ps
module ext_mem_model (
    // Clock
    input  wire logic        pclk,
    // Port strobes and address
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [21:0] addr_out,
    input  wire logic [7:0]  ack_delay,
    // Answers
    output logic             ack,
    output logic      [15:0] data_in
);
    logic [7:0] cnt = 8'h00;

    initial begin
        ack = 1'b0;
    end

    // Ack pulled low between accesses
    always @(posedge pclk) begin
        if (rd_n && wr_n) begin
            cnt <= 8'h00;
            ack <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
            ack <= (cnt >= ack_delay);
        end
    end

    // Asynchronous memory: data follows the strobe; inverted when not read
    assign data_in = rd_n ? ~(addr_out[15:0] ^ 16'h5a5a) : (addr_out[15:0] ^ 16'h5a5a);
endmodule // ext_mem_model

// File: dv/ext_mem_port_wait_and_bus_grant_bench.sv
`timescale 1ns/100ps
module ext_mem_port_wait_and_bus_grant_bench;
    import ext_port_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, adly = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, core_stall, core_done, ack;
    mem_req_t    core_req = '0;
    logic [15:0] core_rdata, data_in, data_out;
    logic [21:0] addr_out, hold_a;
    logic        data_oe_n, addr_oe_n, rd_n, wr_n, mem_iface_clk;
    logic [3:0]  bank_select_lines;
    logic        boot_space_select_n, io_space_select_n, grant_hung_n;
    logic        bus_request_n = 1'b1, bus_grant_n, hold_ok, early;
    logic [5:0]  sel;
    int          err_total = 0, checks = 0, cyc = 0, len, l0, l7, la;

    always #5 pclk = ~pclk;

    ext_mem_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .core_req, .core_booting(1'b0),
        .packer_fill(2'h3), .core_stall, .core_done, .core_rdata, .ack, .data_in,
        .addr_out, .data_out, .data_oe_n, .addr_oe_n, .rd_n, .wr_n,
        .bank_select_lines, .boot_space_select_n, .io_space_select_n,
        .mem_iface_clk, .bus_request_n, .bus_grant_n, .grant_hung_n);

    ext_mem_model u_mem (.pclk, .rd_n, .wr_n, .addr_out, .ack_delay(adly), .ack,
        .data_in);

    task automatic conclude();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 50000) begin
            err_total++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] r,
        input logic [2:0] w, input logic [2:0] c, input logic h);
        return {20'h0, h, c, m, w, r};
    endfunction

    // Core access; measures strobe length, selects and post-strobe hold
    task automatic acc(input logic w, input logic [21:0] a);
        int n;
        n = 0;
        len = 0;
        early = 1'b0;
        @(posedge pclk);
        core_req.valid <= 1'b1;
        core_req.write <= w;
        core_req.addr <= a;
        core_req.wdata <= a[15:0];
        do begin
            @(posedge pclk);
            #1;
            n++;
            if (!rd_n || !wr_n) begin
                len++;
                sel = {boot_space_select_n, io_space_select_n, bank_select_lines};
                hold_a = addr_out;
            end
        end while (core_done !== 1'b1 && n < 3000);
        core_req.valid <= 1'b0;
        // First cycle after the strobe is released
        @(posedge pclk);
        #1;
        hold_ok = (addr_out === hold_a) && (data_out === hold_a[15:0]) && !data_oe_n;
    endtask

    task automatic wait_grant(input logic v);
        int n;
        for (n = 0; n < 12 && bus_grant_n !== v; n++) @(posedge pclk);
    endtask

    initial begin
        core_req.owner = 5'h0b;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFF_PAGE_10, 0);
        check(rdat[15:0], {BANK1_PG_RST, BANK0_PG_RST});
        apb(0, OFF_PAGE_32, 0);
        check(rdat[15:0], {BANK3_PG_RST, BANK2_PG_RST});
        apb(1, OFF_EXT_STATE, 32'hffff);
        apb(0, OFF_EXT_STATE, 0);
        check(rdat[8:7], 2'h3);
        check(rdat[1:0], BSY_IDLE);
        apb(0, 8'h40, 0);
        check(rerr, 1'b1);
        apb(1, OFF_BANK_CTL0, ctl(WMS_COUNT, 0, 0, 0, 0));
        acc(0, 22'h010000);
        l0 = len;
        check(core_rdata, 16'h5a5a);
        check(sel, 6'h3e);
        apb(1, OFF_BANK_CTL0, ctl(WMS_COUNT, 7, 0, 0, 0));
        apb(0, OFF_BANK_CTL0, 0);
        check(rdat[11:0], 12'h047);
        adly = 8'h1e;
        acc(0, 22'h010000);
        l7 = len;
        check(l7 - l0, 7);
        apb(1, OFF_BANK_CTL0, ctl(WMS_ACK, 0, 0, 0, 0));
        adly = 8'h06;
        acc(0, 22'h010000);
        la = len;
        adly = 8'h0c;
        acc(0, 22'h010000);
        check(len - la, 6);
        adly = 8'h00;
        acc(0, 22'h010000);
        check(len >= l0 + 2, 1'b1);
        apb(1, OFF_BANK_CTL0, ctl(WMS_BOTH, 7, 0, 0, 0));
        acc(0, 22'h010000);
        check(len, l7);
        adly = 8'h1e;
        acc(0, 22'h010000);
        check(len > l7, 1'b1);
        apb(1, OFF_BANK_CTL0, ctl(WMS_EITHER, 7, 0, 0, 0));
        acc(0, 22'h010000);
        check(len, l7);
        adly = 8'h00;
        acc(0, 22'h010000);
        check(len < l7, 1'b1);
        for (int k = 0; k < 6; k++) begin
            apb(1, OFF_BANK_CTL0, ctl(WMS_COUNT, 0, 0, k[2:0], 0));
            acc(0, 22'h010000);
            la = len;
            apb(1, OFF_BANK_CTL0, ctl(WMS_COUNT, 3, 0, k[2:0], 0));
            acc(0, 22'h010000);
            check(len - la >= (3 << k) && len - la < (4 << k), 1'b1);
        end
        for (int m = 1; m < 3; m++) begin
            apb(1, OFF_BANK_CTL0, ctl(m[1:0], 0, 2, 1, 1));
            acc(1, 22'h010004);
            check(hold_ok, 1'b1);
        end
        apb(1, OFF_BANK_CTL0, ctl(WMS_COUNT, 7, 7, 3, 0));
        fork
            acc(1, 22'h010008);
            begin
                repeat (20) @(posedge pclk);
                apb(0, OFF_WR_STATUS, 0);
                check(rdat[8], 1'b1);
            end
        join
        apb(0, OFF_WR_STATUS, 0);
        check(rdat[8], 1'b0);
        apb(0, OFF_EXT_STATE, 0);
        check(rdat[6:2], 5'h0b);
        for (int b = 0; b < 4; b++) begin
            acc(0, {(b == 0) ? 8'h01 : 8'(b << 6), 14'h0010});
            check(sel, {2'b11, ~(4'h1 << b)});
        end
        apb(1, OFF_PAGE_10, 32'h2001);
        acc(0, 22'h0c0000);
        check(sel, 6'h3d);
        core_req.boot = 1'b1;
        acc(0, 22'h000100);
        check(sel, 6'h1f);
        core_req.boot = 1'b0;
        core_req.io = 1'b1;
        acc(0, 22'h000100);
        check(sel, 6'h2f);
        core_req.io = 1'b0;
        // master holds request low while it uses the bus
        bus_request_n <= 1'b0;
        wait_grant(1'b0);
        check(bus_grant_n, 1'b0);
        fork
            acc(0, 22'h010010);
            begin
                repeat (10) @(posedge pclk);
                check(grant_hung_n, 1'b0);
                check(core_stall, 1'b1);
                bus_request_n <= 1'b1;
            end
        join
        check(core_rdata, 16'h5a4a);
        fork
            acc(0, 22'h010000);
            begin
                repeat (6) @(posedge pclk);
                bus_request_n <= 1'b0;
                while (core_done !== 1'b1) begin
                    @(posedge pclk);
                    #1;
                    if (!bus_grant_n) early = 1'b1;
                end
            end
        join
        check(early, 1'b0);
        wait_grant(1'b0);
        check(bus_grant_n, 1'b0);
        @(posedge pclk);
        bus_request_n <= 1'b1;
        apb(1, OFF_PORT_CTL, 32'h1);
        bus_request_n <= 1'b0;
        repeat (20) @(posedge pclk);
        check(bus_grant_n, 1'b1);
        bus_request_n <= 1'b1;
        apb(1, OFF_PORT_CTL, 32'h0);
        conclude();
    end
endmodule // ext_mem_port_wait_and_bus_grant_bench
